// ---- hdl/vfs_pkg.sv ----
// package: constants and types for the display scan sequencer
package vfs_pkg;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] VFS_MODE1_ADDR  = 16'hFFB0;
    localparam logic [15:0] VFS_MODE2_ADDR  = 16'hFFB2;
    localparam logic [15:0] VFS_MODE3_ADDR  = 16'hFFB4;
    localparam logic [7:0]  VFS_MODE1_RST   = 8'h10;
    localparam logic [7:0]  VFS_MODE2_RST   = 8'h01;
    localparam logic [7:0]  VFS_MODE3_RST   = 8'h00;
    localparam int          VFS_KSF_BIT     = 7;
    localparam int          VFS_KSM_BIT     = 6;
    localparam int          VFS_EN_BIT      = 7;
    localparam logic [7:0]  VFS_MODE3_WMASK = 8'h43;
    // ------------------------------------------------------------------
    // display RAM
    // ------------------------------------------------------------------
    localparam logic [15:0] VFS_RAM_BASE    = 16'hEA00;
    localparam int          VFS_RAM_BYTES   = 96;
    localparam int          VFS_BLOCK_BYTES = 6;
    localparam int          VFS_OUTS        = 48;
    localparam int          VFS_SHARED_LO   = 16;
    // ------------------------------------------------------------------
    // timing: period = 16 sub-intervals of 2^(9-sel) clocks
    // ------------------------------------------------------------------
    localparam int          VFS_SUBS        = 16;
    localparam int          VFS_SUB_LOG_MAX = 9;

    typedef enum logic [1:0] {
        VFS_IDLE,
        VFS_SHOW,
        VFS_SCAN
    } vfs_state_t;

    // processor memory access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        bit_op;
        logic [2:0]  bit_sel;
    } vfs_req_t;
endpackage

// ---- hdl/vfs_ram.sv ----
// dual-port display data memory, processor port and scan port
`timescale 1ns/1ps
`default_nettype none
module vfs_ram
    import vfs_pkg::*;
#(
    parameter int DEPTH = VFS_RAM_BYTES
) (
    input  wire logic       ref_clk,
    input  wire logic [6:0] cpu_addr,
    input  wire logic       cpu_we,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    input  wire logic [6:0] scan_addr,
    output logic      [7:0] scan_rdata
);
    logic [7:0] mem [DEPTH];

    // processor port, plain read/write storage
    always_ff @(posedge ref_clk) begin
        if (cpu_we) begin
            mem[cpu_addr] <= cpu_wdata;
        end
        cpu_rdata <= mem[cpu_addr];
    end

    // independent scan port, never stalls the processor
    always_ff @(posedge ref_clk) begin
        scan_rdata <= mem[scan_addr];
    end
endmodule
`default_nettype wire

// ---- hdl/vfs_top.sv ----
// display scan sequencer with key-scan slot and display RAM
`timescale 1ns/1ps
`default_nettype none
module vfs_top
    import vfs_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire vfs_req_t             cpu_req,
    output logic     [7:0]            cpu_rdata,
    output logic                      cpu_hit,
    input  wire logic [31:0]          port_latch,
    output logic     [VFS_OUTS-1:0]   disp_out,
    output logic                      disp_active,
    output logic                      key_scan_pulse
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] mode1_reg;
    logic [7:0] mode2_reg;
    logic [7:0] mode3_reg;
    logic       key_scan_active_flag;
    vfs_state_t state_reg;
    logic [3:0] slot_reg;
    logic [3:0] sub_reg;
    logic [8:0] tick_reg;
    logic [2:0] fetch_reg;
    logic [VFS_OUTS-1:0] pat_reg;
    logic [VFS_OUTS-1:0] shown_reg;
    logic       fetch_busy;

    wire logic display_enable_bit = mode1_reg[VFS_EN_BIT];
    wire logic key_scan_insert_select = mode3_reg[VFS_KSM_BIT];
    wire logic [1:0] period_sel = mode3_reg[1:0];
    wire logic [2:0] blank_sel = mode2_reg[7:5];
    wire logic [4:0] pattern_count = mode2_reg[4:0];

    // byte address decode, shared by read and write paths
    function automatic logic in_ram(input logic [15:0] a);
        return (a >= VFS_RAM_BASE) &&
               (a < VFS_RAM_BASE + 16'(VFS_RAM_BYTES));
    endfunction

    // blank share in sixteenths
    function automatic logic [3:0] blank_16(input logic [2:0] s);
        return (s == 3'h0) ? 4'h1 : {s, 1'b0};
    endfunction

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    logic [7:0] wr_val;
    logic [7:0] cur_val;
    always_comb begin
        unique case (cpu_req.addr)
            VFS_MODE1_ADDR: cur_val = mode1_reg;
            VFS_MODE2_ADDR: cur_val = mode2_reg;
            VFS_MODE3_ADDR: cur_val = mode3_reg;
            default:        cur_val = 8'h00;
        endcase
        wr_val = cur_val;
        if (cpu_req.bit_op) begin
            wr_val[cpu_req.bit_sel] = cpu_req.wdata[0];
        end else begin
            wr_val = cpu_req.wdata;
        end
    end

    // mode registers; writes during display are software's duty
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode1_reg <= VFS_MODE1_RST;
            mode2_reg <= VFS_MODE2_RST;
            mode3_reg <= VFS_MODE3_RST;
        end else if (cpu_req.wr) begin
            if (cpu_req.addr == VFS_MODE1_ADDR) begin
                mode1_reg <= wr_val & 8'hBF;
            end
            if (cpu_req.addr == VFS_MODE2_ADDR) begin
                mode2_reg <= wr_val;
            end
            if (cpu_req.addr == VFS_MODE3_ADDR) begin
                mode3_reg <= wr_val & VFS_MODE3_WMASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // processor read path
    // ------------------------------------------------------------------
    logic [7:0] ram_rdata;
    logic       rd_ram_reg;
    logic [7:0] reg_rdata_reg;
    logic [7:0] mode3_view;
    always_comb begin
        mode3_view = mode3_reg;
        mode3_view[VFS_KSF_BIT] = key_scan_active_flag;
    end

    // registered read data; mode3 bit reads return the bit in bit 0
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_ram_reg    <= 1'b0;
            reg_rdata_reg <= 8'h00;
            cpu_hit       <= 1'b0;
        end else begin
            rd_ram_reg <= in_ram(cpu_req.addr);
            cpu_hit    <= cpu_req.rd &&
                          (in_ram(cpu_req.addr) ||
                           cpu_req.addr == VFS_MODE1_ADDR ||
                           cpu_req.addr == VFS_MODE2_ADDR ||
                           cpu_req.addr == VFS_MODE3_ADDR);
            if (cpu_req.addr == VFS_MODE3_ADDR && cpu_req.bit_op) begin
                reg_rdata_reg <= {7'h00,
                    mode3_view[cpu_req.bit_sel]};
            end else if (cpu_req.addr == VFS_MODE3_ADDR) begin
                reg_rdata_reg <= mode3_view;
            end else begin
                reg_rdata_reg <= cur_val;
            end
        end
    end
    assign cpu_rdata = rd_ram_reg ? ram_rdata : reg_rdata_reg;

    logic [15:0] ram_off;
    logic [6:0]  scan_addr;
    logic [7:0]  scan_rdata;
    assign ram_off = cpu_req.addr - VFS_RAM_BASE;

    vfs_ram #(
        .DEPTH(VFS_RAM_BYTES)
    ) u_ram (
        .ref_clk   (ref_clk),
        .cpu_addr  (ram_off[6:0]),
        .cpu_we    (cpu_req.wr && in_ram(cpu_req.addr)),
        .cpu_wdata (cpu_req.wdata),
        .cpu_rdata (ram_rdata),
        .scan_addr (scan_addr),
        .scan_rdata(scan_rdata)
    );

    // ------------------------------------------------------------------
    // period timing
    // ------------------------------------------------------------------
    logic [8:0] tick_last;
    logic       sub_done;
    logic       period_done;
    assign tick_last = 9'((1 << (VFS_SUB_LOG_MAX - 32'(period_sel))) - 1);
    assign sub_done    = (tick_reg == tick_last);
    assign period_done = sub_done && (sub_reg == 4'(VFS_SUBS - 1));

    // tick and sub-interval counters
    always_ff @(posedge ref_clk) begin
        if (rst || state_reg == VFS_IDLE) begin
            tick_reg <= 9'h000;
            sub_reg  <= 4'h0;
        end else if (sub_done) begin
            tick_reg <= 9'h000;
            sub_reg  <= sub_reg + 4'h1;
        end else begin
            tick_reg <= tick_reg + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // slot sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= VFS_IDLE;
            slot_reg  <= 4'h0;
        end else if (!display_enable_bit) begin
            state_reg <= VFS_IDLE;
            slot_reg  <= 4'h0;
        end else begin
            unique case (state_reg)
                VFS_IDLE: begin
                    state_reg <= VFS_SHOW;
                    slot_reg  <= 4'h0;
                end
                VFS_SHOW: if (period_done) begin
                    if (slot_reg != pattern_count[3:0]) begin
                        slot_reg <= slot_reg + 4'h1;
                    end else if (key_scan_insert_select) begin
                        state_reg <= VFS_SCAN;
                    end else begin
                        slot_reg <= 4'h0;
                    end
                end
                VFS_SCAN: if (period_done) begin
                    state_reg <= VFS_SHOW;
                    slot_reg  <= 4'h0;
                end
            endcase
        end
    end

    // flag follows the scan slot, cleared when display resumes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            key_scan_active_flag <= 1'b0;
        end else begin
            key_scan_active_flag <= (state_reg == VFS_SCAN);
        end
    end
    assign key_scan_pulse = (state_reg == VFS_SCAN) && (sub_reg == 4'h0)
                            && (tick_reg == 9'h000);
    assign disp_active = (state_reg != VFS_IDLE);

    // ------------------------------------------------------------------
    // pattern fetch: six bytes at period start into staging register
    // ------------------------------------------------------------------
    logic [3:0] fetch_slot;
    assign fetch_busy = (fetch_reg != 3'h0);
    // fetch runs one period ahead: block of the slot that comes next
    assign fetch_slot = (state_reg == VFS_SHOW &&
                         slot_reg != pattern_count[3:0]) ? slot_reg + 4'h1 :
                        4'h0;
    assign scan_addr = 7'(fetch_slot) * 7'(VFS_BLOCK_BYTES)
                       + 7'(fetch_reg - 3'h1);

    // byte k lands in outputs 8k..8k+7, lowest bit first
    always_ff @(posedge ref_clk) begin
        if (rst || state_reg == VFS_IDLE) begin
            fetch_reg <= 3'h0;
            pat_reg   <= '0;
        end else if (period_done || (sub_reg == 4'h0 && tick_reg == 9'h000
                     && fetch_reg == 3'h0 && !fetch_busy && slot_reg == 4'h0
                     && state_reg == VFS_SHOW && pat_reg == '0)) begin
            fetch_reg <= 3'h1;
        end else if (fetch_busy) begin
            fetch_reg <= (fetch_reg == 3'(VFS_BLOCK_BYTES + 1)) ? 3'h0 :
                         fetch_reg + 3'h1;
            if (fetch_reg >= 3'h2) begin
                pat_reg[8*(fetch_reg - 3'h2) +: 8] <= scan_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // output drive with symmetric blanking
    // ------------------------------------------------------------------
    logic [4:0] half_lo;
    logic       lit;
    always_comb begin
        half_lo = {1'b0, blank_16(blank_sel)} >> 1;
        if (blank_sel == 3'h0) begin
            lit = !((sub_reg == 4'h0 && tick_reg <= (tick_last >> 1)) ||
                    (sub_reg == 4'hF && tick_reg > (tick_last >> 1)));
        end else begin
            lit = (5'(sub_reg) >= half_lo) &&
                  (5'(sub_reg) < 5'(VFS_SUBS) - half_lo);
        end
    end

    // latch pattern at period start; scan slot shows port latches
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shown_reg <= '0;
            disp_out  <= '0;
        end else begin
            if (sub_reg == 4'h0 && tick_reg == 9'h000) begin
                shown_reg <= pat_reg;
            end
            unique case (state_reg)
                VFS_IDLE: disp_out <= '0;
                VFS_SHOW: disp_out <= lit ? shown_reg : '0;
                VFS_SCAN: disp_out <= {port_latch,
                                       16'h0000};
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- sim/vfs_top_properties.sv ----
// checker: port-level properties of the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module vfs_top_properties
    import vfs_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire vfs_req_t            cpu_req,
    input wire logic [7:0]          cpu_rdata,
    input wire logic                cpu_hit,
    input wire logic [31:0]         port_latch,
    input wire logic [VFS_OUTS-1:0] disp_out,
    input wire logic                disp_active,
    input wire logic                key_scan_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic map;
    int   gap_reg;
    logic seen_reg;
    // mapped addresses: mode registers and display ram
    assign map = cpu_req.addr == VFS_MODE1_ADDR ||
        cpu_req.addr == VFS_MODE2_ADDR || cpu_req.addr == VFS_MODE3_ADDR ||
        (cpu_req.addr >= VFS_RAM_BASE && cpu_req.addr <= 16'hEA5F);
    // cycles since the last key-scan slot began
    always_ff @(posedge ref_clk) begin
        if (rst || !disp_active) begin
            gap_reg  <= 0;
            seen_reg <= 1'b0;
        end else if (key_scan_pulse) begin
            gap_reg  <= 1;
            seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 1;
        end
    end
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> disp_out == 48'h0 && !cpu_hit) else $error("reset leak");
    a_mapped_hit: assert property (cpu_req.rd && map |=> cpu_hit)
        else $error("mapped read missed");
    a_unmapped_read: assert property (cpu_req.rd && !map |=>
        !cpu_hit && cpu_rdata == 8'h00) else $error("unmapped read hit");
    a_bit_read: assert property (cpu_req.rd && cpu_req.bit_op &&
        cpu_req.addr == VFS_MODE3_ADDR |=> cpu_rdata[7:1] == 7'h00)
        else $error("bit read shape");
    a_mode3_zeros: assert property (cpu_req.rd &&
        cpu_req.addr == VFS_MODE3_ADDR |=> cpu_rdata[5:2] == 4'h0)
        else $error("mode3 reserved bits set");
    a_flag_idle: assert property (cpu_req.rd && !cpu_req.bit_op &&
        cpu_req.addr == VFS_MODE3_ADDR && !disp_active &&
        !$past(disp_active) |=> !cpu_rdata[7]) else $error("flag idle");
    a_scan_low: assert property (key_scan_pulse |=>
        disp_out[15:0] == 16'h0000) else $error("scan outputs not low");
    a_scan_ports: assert property (key_scan_pulse |-> ##300
        disp_out[47:16] == port_latch) else $error("scan latch missing");
    a_scan_active: assert property (key_scan_pulse |-> disp_active)
        else $error("scan while disabled");
    a_scan_spacing: assert property (key_scan_pulse && seen_reg |->
        gap_reg >= 3072) else $error("scan slots too close");
    c_scan: cover property (key_scan_pulse);
    c_bit_read: cover property (cpu_req.rd && cpu_req.bit_op);
    c_miss: cover property (cpu_req.rd && !map);
endmodule
bind vfs_top vfs_top_properties u_props (.ref_clk, .rst, .cpu_req,
    .cpu_rdata, .cpu_hit, .port_latch, .disp_out, .disp_active,
    .key_scan_pulse);
`default_nettype wire

// ---- sim/vfs_panel.sv ----
// panel and key matrix model watching the display outputs
`timescale 1ns/1ps
`default_nettype none
module vfs_panel
    import vfs_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic [VFS_OUTS-1:0] disp_out,
    input  wire logic                key_scan_pulse,
    output logic      [15:0]         scan_count
);
    // key matrix counts scan slots that open with the grids dark
    initial scan_count = 16'h0000;
    always @(posedge ref_clk) begin
        if (key_scan_pulse && disp_out[15:0] == 16'h0000) begin
            scan_count <= scan_count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- sim/vfs_top_tb.sv ----
// testbench for the display scan sequencer
`timescale 1ns/1ps
`default_nettype none
module vfs_top_tb
    import vfs_pkg::*;
;
    typedef struct packed {
        logic wr; logic [15:0] a; logic [7:0] d; logic b;
        logic [7:0] e; logic h;
    } vfs_row_t;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    vfs_req_t    req = '0;
    logic [31:0] plat = 32'h5AC3_96E1;
    logic [7:0]  rdata;
    logic        hit;
    logic        act;
    logic        ksp;
    logic [47:0] dout;
    logic [15:0] scans;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          t0;
    int          s;
    // register rows: write/read, address, data, bit op, result, hit
    vfs_row_t rows [11] = '{
        '{1'b0, 16'hFFB4, 8'h00, 1'b0, 8'h00, 1'b1},
        '{1'b1, 16'hFFB4, 8'hC3, 1'b0, 8'h00, 1'b0},
        '{1'b0, 16'hFFB4, 8'h00, 1'b0, 8'h43, 1'b1},
        '{1'b0, 16'hFFB4, 8'h00, 1'b1, 8'h00, 1'b1},
        '{1'b1, 16'hFFB4, 8'h00, 1'b0, 8'h00, 1'b0},
        '{1'b1, 16'hFFB4, 8'h01, 1'b1, 8'h00, 1'b0},
        '{1'b0, 16'hFFB4, 8'h00, 1'b0, 8'h00, 1'b1},
        '{1'b1, 16'hEA5F, 8'hA5, 1'b0, 8'h00, 1'b0},
        '{1'b0, 16'hEA5F, 8'h00, 1'b0, 8'hA5, 1'b1},
        '{1'b0, 16'hEA60, 8'h00, 1'b0, 8'h00, 1'b0},
        '{1'b0, 16'hE9FF, 8'h00, 1'b0, 8'h00, 1'b0}};
    vfs_top dut (.ref_clk, .rst, .cpu_req(req), .cpu_rdata(rdata),
        .cpu_hit(hit), .port_latch(plat), .disp_out(dout),
        .disp_active(act), .key_scan_pulse(ksp));
    vfs_panel panel (.ref_clk, .disp_out(dout), .key_scan_pulse(ksp),
        .scan_count(scans));
    // clock and cycle count
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    function automatic logic [7:0] pat(int i);
        return 8'(i * 29 + 1);
    endfunction
    function automatic logic [47:0] blk(int n);
        for (int k = 0; k < 6; k++) blk[8*k +: 8] = pat(6 * n + k);
    endfunction
    // one processor access, result sampled in the answer cycle
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic b);
        @(posedge ref_clk);
        req <= '{w, !w, a, d, b, 3'h7};
        @(posedge ref_clk);
        req <= '0;
        #1;
    endtask
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_pat(input logic [47:0] e, input logic [47:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wait_to(input int n);
        while (cyc < n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_scan;
        @(posedge ref_clk);
        #1;
        for (int k = 0; k < 30000 && ksp !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        t0 = cyc;
    endtask
    // mode change only while the display is off
    task automatic mode(input logic [1:0] c, input logic k);
        wait_to(cyc + 400);
        acc(1'b1, VFS_MODE1_ADDR, 8'h2F, 1'b0);
        acc(1'b1, VFS_MODE3_ADDR, {1'b0, k, 4'h0, c}, 1'b0);
        acc(1'b1, VFS_MODE1_ADDR, 8'hAF, 1'b0);
    endtask
    task automatic test_done;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog well past the longest scan sequence
    initial begin
        #400us;
        miscompares++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].a, rows[i].d, rows[i].b);
            if (!rows[i].wr) begin
                cmp_byte(rows[i].e, rdata);
                cmp_byte({7'h00, rows[i].h}, {7'h00, hit});
            end
        end
        for (int i = 0; i < 12; i++) begin
            acc(1'b1, VFS_RAM_BASE + 16'(i), pat(i), 1'b0);
        end
        acc(1'b1, VFS_MODE2_ADDR, 8'h01, 1'b0);
        for (int c = 0; c < 4; c++) begin
            mode(2'(c), 1'b1);
            wait_scan();
            s = t0;
            wait_scan();
            cmp_pat(48'(48 * (1 << (9 - c))), 48'(t0 - s));
        end
        wait_to(t0 + 512);
        cmp_pat({plat, 16'h0000}, dout);
        acc(1'b0, VFS_MODE3_ADDR, 8'h00, 1'b1);
        cmp_byte(8'h01, rdata);
        wait_to(t0 + 1032);
        cmp_pat(48'h0, dout);
        wait_to(t0 + 1536);
        cmp_pat(blk(0), dout);
        acc(1'b0, VFS_MODE3_ADDR, 8'h00, 1'b1);
        cmp_byte(8'h00, rdata);
        wait_to(t0 + 2040);
        cmp_pat(48'h0, dout);
        wait_to(t0 + 2560);
        cmp_pat(blk(1), dout);
        cmp_pat(48'h8, 48'(scans));
        mode(2'h3, 1'b0);
        s = int'(scans);
        wait_to(cyc + 4000);
        cmp_pat(48'(s), 48'(scans));
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        acc(1'b0, VFS_MODE3_ADDR, 8'h00, 1'b0);
        cmp_byte(8'h00, rdata);
        cmp_pat(48'h0, dout);
        test_done();
    end
endmodule
`default_nettype wire
